// File: src/dcar_regs.vh
// register offsets, field positions, reset values and codes of the channel arm/request block
`ifndef DCAR_REGS_VH
`define DCAR_REGS_VH

// ---------------------------------------------------------------
// special-function register offsets
// ---------------------------------------------------------------
`define DCAR_ADR_CH14_BASE_LO 8'hd2
`define DCAR_ADR_CH14_BASE_HI 8'hd3
`define DCAR_ADR_CH0_BASE_LO 8'hd4
`define DCAR_ADR_CH0_BASE_HI 8'hd5
`define DCAR_ADR_ARM 8'hd6
`define DCAR_ADR_REQ 8'hd7

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define DCAR_RST_BYTE 8'h00
`define DCAR_RST_PTR 16'h0000
`define DCAR_RST_CH 5'h00

// ---------------------------------------------------------------
// arm register fields
// ---------------------------------------------------------------
`define DCAR_ARM_ABORT_BIT 7
`define DCAR_ARM_SPARE_HI 6
`define DCAR_ARM_SPARE_LO 5
`define DCAR_ARM_CH_HI 4

// ---------------------------------------------------------------
// descriptor layout
// ---------------------------------------------------------------
`define DCAR_DESC_REC_BYTES 16'h0008
`define DCAR_DESC_OFF_MODE 3'h6
`define DCAR_DESC_OFF_MASK 3'h7
`define DCAR_DESC_TRANSFER_MODE_HI 6
`define DCAR_DESC_TRANSFER_MODE_LO 5
`define DCAR_DESC_TRIGGER_SELECT_HI 4
`define DCAR_DESC_TRIGGER_SELECT_LO 0
`define DCAR_DESC_DONE_INTERRUPT_MASK_BIT 3

// ---------------------------------------------------------------
// codes
// ---------------------------------------------------------------
`define DCAR_TRIGGER_SELECT_NONE 5'h00
`define DCAR_TRIGGER_SELECT_PREV 5'h01
`define DCAR_TRANSFER_MODE_SINGLE 2'h0
`define DCAR_TRANSFER_MODE_BLOCK 2'h1
`define DCAR_TRANSFER_MODE_RPT_SINGLE 2'h2
`define DCAR_TRANSFER_MODE_RPT_BLOCK 2'h3

`endif

// File: src/dcar_buf2.v
// two-entry valid/ready buffer for descriptor bytes returned by memory
`timescale 1ns/1ps
module dcar_buf2 #(
   parameter WIDTH = 8
) (
   input wire core_clk,
   input wire arst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] ent0_r;
   reg [WIDTH-1:0] ent1_r;
   reg [1:0] cnt_r;
   wire push;
   wire pop;

   assign in_ready = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = ent0_r;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ent0_r <= {WIDTH{1'b0}};
         ent1_r <= {WIDTH{1'b0}};
         cnt_r <= 2'h0;
      end
      else
      begin
         case ({push, pop})
            2'b10:
            begin
               if (cnt_r == 2'h0)
                  ent0_r <= in_data;
               else
                  ent1_r <= in_data;
               cnt_r <= cnt_r + 2'h1;
            end
            2'b01:
            begin
               ent0_r <= ent1_r;
               cnt_r <= cnt_r - 2'h1;
            end
            2'b11:
            begin
               // full never pushes, so both at once means one entry held
               ent0_r <= in_data;
            end
            default:
            begin
               cnt_r <= cnt_r;
            end
         endcase
      end
   end

endmodule

// File: src/dcar_desc_addr.v
// descriptor byte address from channel number and base pointers
`timescale 1ns/1ps
`include "dcar_regs.vh"
module dcar_desc_addr (
   input wire [2:0] ch,
   input wire [15:0] base0,
   input wire [15:0] base1,
   input wire [2:0] byte_off,
   output reg [15:0] addr
);

   reg [15:0] rec;

   always @*
   begin
      rec = 16'h0000;
      addr = 16'h0000;
      if (ch == 3'h0)
         addr = base0 + {13'h0000, byte_off};
      else
      begin
         // channels 1..4 sit back to back behind the shared pointer
         rec = {13'h0000, ch - 3'h1} * `DCAR_DESC_REC_BYTES;
         addr = base1 + rec + {13'h0000, byte_off};
      end
   end

endmodule

// File: src/dcar_top.v
// five-channel dma arm, abort, start request and descriptor pointer control
`timescale 1ns/1ps
`include "dcar_regs.vh"
module dcar_top #(
   parameter NCH = 5,
   parameter NTRIG = 32
) (
   input wire core_clk,
   input wire arst_n,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   input wire sfr_we,
   input wire sfr_re,
   output wire [7:0] sfr_rdata,
   output wire sfr_rvalid,
   input wire [NTRIG-1:0] trigger_select_in,
   output wire mem_rd_req,
   output wire [15:0] mem_rd_addr,
   input wire mem_rd_valid,
   output wire mem_rd_ready,
   input wire [7:0] mem_rd_data,
   output wire xfer_start,
   output wire [2:0] xfer_ch,
   output wire [1:0] xfer_transfer_mode,
   output wire [15:0] xfer_desc_addr,
   output wire xfer_abort,
   input wire xfer_done,
   output wire [NCH-1:0] done_flag_set,
   output wire done_irq,
   output wire [NCH-1:0] channel_arm,
   output wire busy
);

   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   localparam S_IDLE = 6'b000001;
   localparam S_F6 = 6'b000010;
   localparam S_W6 = 6'b000100;
   localparam S_F7 = 6'b001000;
   localparam S_W7 = 6'b010000;
   localparam S_RUN = 6'b100000;

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   reg [NCH-1:0] arm_r, arm_nxt;
   reg [1:0] spare_r;
   reg [NCH-1:0] req_r, req_nxt;
   reg [NCH-1:0] hw_pend_r, hw_pend_nxt;
   reg [NCH-1:0] loaded_r, loaded_nxt;
   reg [NCH-1:0] fetch_pend_r, fetch_pend_nxt;
   reg [2*NCH-1:0] transfer_mode_r, transfer_mode_nxt;
   reg [5*NCH-1:0] trigger_select_r, trigger_select_nxt;
   reg [NCH-1:0] mask_r, mask_nxt;
   reg [5:0] state_r, state_nxt;
   reg [2:0] cur_r, cur_nxt;
   reg [15:0] base0_r;
   reg [15:0] base1_r;
   reg [7:0] rdata_r;
   reg rvalid_r;
   reg xfer_start_r, xfer_start_nxt;
   reg xfer_abort_r, xfer_abort_nxt;
   reg [1:0] xfer_transfer_mode_r, xfer_transfer_mode_nxt;
   reg [15:0] xfer_desc_r, xfer_desc_nxt;
   reg [NCH-1:0] done_set_r, done_set_nxt;
   reg done_irq_r, done_irq_nxt;
   reg mem_req_r, mem_req_nxt;
   reg [15:0] mem_addr_r, mem_addr_nxt;

   wire wr_arm;
   wire abort_wr;
   wire [NCH-1:0] sw_val;
   wire [NCH-1:0] sw_set;
   wire [NCH-1:0] hit;
   wire [NCH-1:0] pend;
   wire buf_valid;
   wire buf_ready;
   wire [7:0] buf_data;
   wire [15:0] fetch_addr;
   wire [15:0] desc_base;
   reg [2:0] fetch_sel;
   reg [2:0] run_sel;
   reg [NCH-1:0] hw_clr;
   reg [NCH-1:0] grant;
   integer k;

   // ---------------------------------------------------------------
   // software write decode
   // ---------------------------------------------------------------
   assign wr_arm = sfr_we && (sfr_addr == `DCAR_ADR_ARM);
   assign abort_wr = wr_arm && sfr_wdata[`DCAR_ARM_ABORT_BIT];
   // abort drops the selected arms, a plain write loads them
   assign sw_val = abort_wr ? (arm_r & ~sfr_wdata[NCH-1:0]) : sfr_wdata[NCH-1:0];
   assign sw_set = (wr_arm && !abort_wr) ? sfr_wdata[NCH-1:0] : `DCAR_RST_CH;

   // ---------------------------------------------------------------
   // trigger matching per channel
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1)
      begin : g_ch
         wire [4:0] sel = trigger_select_r[5*g+4:5*g];
         wire prev_done = done_set_r[(g + NCH - 1) % NCH];
         // select zero never matches, leaving software as the only start
         assign hit[g] = arm_r[g] && loaded_r[g] &&
            (((sel == `DCAR_TRIGGER_SELECT_PREV) && prev_done) ||
             ((sel != `DCAR_TRIGGER_SELECT_NONE) && (sel != `DCAR_TRIGGER_SELECT_PREV) && trigger_select_in[sel]));
         assign pend[g] = (req_r[g] || hw_pend_r[g]) && arm_r[g] && loaded_r[g];
      end
   endgenerate

   // ---------------------------------------------------------------
   // descriptor addressing and return buffer
   // ---------------------------------------------------------------
   dcar_desc_addr u_addr (
      .ch(cur_r),
      .base0(base0_r),
      .base1(base1_r),
      .byte_off((state_r == S_F7) ? `DCAR_DESC_OFF_MASK : `DCAR_DESC_OFF_MODE),
      .addr(fetch_addr)
   );

   dcar_desc_addr u_base (
      .ch(run_sel),
      .base0(base0_r),
      .base1(base1_r),
      .byte_off(3'h0),
      .addr(desc_base)
   );

   // drained only while a fetch waits, so late bytes wait in the buffer and memory stalls only once it holds two
   assign buf_ready = (state_r == S_W6) || (state_r == S_W7);

   dcar_buf2 #(
      .WIDTH(8)
   ) u_buf (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .in_valid(mem_rd_valid),
      .in_ready(mem_rd_ready),
      .in_data(mem_rd_data),
      .out_valid(buf_valid),
      .out_ready(buf_ready),
      .out_data(buf_data)
   );

   // ---------------------------------------------------------------
   // channel selection, lowest index first
   // ---------------------------------------------------------------
   always @*
   begin
      fetch_sel = 3'h0;
      run_sel = 3'h0;
      for (k = NCH - 1; k >= 0; k = k - 1)
      begin
         if (fetch_pend_r[k])
            fetch_sel = k[2:0];
         if (pend[k])
            run_sel = k[2:0];
      end
   end

   // ---------------------------------------------------------------
   // sequencer and next-state
   // ---------------------------------------------------------------
   always @*
   begin
      state_nxt = state_r;
      cur_nxt = cur_r;
      hw_clr = `DCAR_RST_CH;
      grant = `DCAR_RST_CH;
      loaded_nxt = loaded_r;
      fetch_pend_nxt = fetch_pend_r;
      transfer_mode_nxt = transfer_mode_r;
      trigger_select_nxt = trigger_select_r;
      mask_nxt = mask_r;
      xfer_start_nxt = 1'b0;
      xfer_abort_nxt = 1'b0;
      xfer_transfer_mode_nxt = xfer_transfer_mode_r;
      xfer_desc_nxt = xfer_desc_r;
      done_set_nxt = `DCAR_RST_CH;
      done_irq_nxt = 1'b0;
      mem_req_nxt = 1'b0;
      mem_addr_nxt = mem_addr_r;
      case (state_r)
         S_IDLE:
         begin
            if (|fetch_pend_r)
            begin
               cur_nxt = fetch_sel;
               state_nxt = S_F6;
            end
            else if (|pend)
            begin
               cur_nxt = run_sel;
               grant[run_sel] = 1'b1;
               xfer_start_nxt = 1'b1;
               xfer_transfer_mode_nxt = transfer_mode_r[2*run_sel +: 2];
               xfer_desc_nxt = desc_base;
               state_nxt = S_RUN;
            end
         end
         S_F6, S_F7:
         begin
            mem_req_nxt = 1'b1;
            mem_addr_nxt = fetch_addr;
            state_nxt = (state_r == S_F6) ? S_W6 : S_W7;
         end
         S_W6:
         begin
            if (buf_valid)
            begin
               transfer_mode_nxt[2*cur_r +: 2] = buf_data[`DCAR_DESC_TRANSFER_MODE_HI:`DCAR_DESC_TRANSFER_MODE_LO];
               trigger_select_nxt[5*cur_r +: 5] = buf_data[`DCAR_DESC_TRIGGER_SELECT_HI:`DCAR_DESC_TRIGGER_SELECT_LO];
               state_nxt = S_F7;
            end
         end
         S_W7:
         begin
            if (buf_valid)
            begin
               mask_nxt[cur_r] = buf_data[`DCAR_DESC_DONE_INTERRUPT_MASK_BIT];
               loaded_nxt[cur_r] = 1'b1;
               fetch_pend_nxt[cur_r] = 1'b0;
               state_nxt = S_IDLE;
            end
         end
         S_RUN:
         begin
            if (!arm_r[cur_r])
            begin
               // a dropped arm halts the run; a cleared request does not
               xfer_abort_nxt = 1'b1;
               state_nxt = S_IDLE;
            end
            else if (xfer_done)
            begin
               done_set_nxt[cur_r] = 1'b1;
               done_irq_nxt = mask_r[cur_r];
               if (!transfer_mode_r[2*cur_r + 1])
                  hw_clr[cur_r] = 1'b1;
               state_nxt = S_IDLE;
            end
         end
         default:
         begin
            state_nxt = S_IDLE;
         end
      endcase
      // software set of an arm wins over the completion clear
      arm_nxt = (wr_arm ? sw_val : arm_r) & ~(hw_clr & ~sw_set);
      // a fresh arm reloads the descriptor; a dropped arm forgets it
      fetch_pend_nxt = (fetch_pend_nxt | (arm_nxt & ~arm_r)) & arm_nxt;
      loaded_nxt = loaded_nxt & arm_nxt & ~(arm_nxt & ~arm_r);
      req_nxt = req_r & ~grant;
      if (sfr_we && (sfr_addr == `DCAR_ADR_REQ))
         req_nxt = req_nxt | sfr_wdata[NCH-1:0];
      hw_pend_nxt = ((hw_pend_r & ~grant) | hit) & arm_nxt;
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         arm_r <= `DCAR_RST_CH;
         spare_r <= 2'h0;
         req_r <= `DCAR_RST_CH;
         hw_pend_r <= `DCAR_RST_CH;
         loaded_r <= `DCAR_RST_CH;
         fetch_pend_r <= `DCAR_RST_CH;
         transfer_mode_r <= {2*NCH{1'b0}};
         trigger_select_r <= {5*NCH{1'b0}};
         mask_r <= `DCAR_RST_CH;
         state_r <= S_IDLE;
         cur_r <= 3'h0;
         base0_r <= `DCAR_RST_PTR;
         base1_r <= `DCAR_RST_PTR;
         rdata_r <= `DCAR_RST_BYTE;
         rvalid_r <= 1'b0;
         xfer_start_r <= 1'b0;
         xfer_abort_r <= 1'b0;
         xfer_transfer_mode_r <= `DCAR_TRANSFER_MODE_SINGLE;
         xfer_desc_r <= `DCAR_RST_PTR;
         done_set_r <= `DCAR_RST_CH;
         done_irq_r <= 1'b0;
         mem_req_r <= 1'b0;
         mem_addr_r <= `DCAR_RST_PTR;
      end
      else
      begin
         arm_r <= arm_nxt;
         if (wr_arm)
            spare_r <= sfr_wdata[`DCAR_ARM_SPARE_HI:`DCAR_ARM_SPARE_LO];
         req_r <= req_nxt;
         hw_pend_r <= hw_pend_nxt;
         loaded_r <= loaded_nxt;
         fetch_pend_r <= fetch_pend_nxt;
         transfer_mode_r <= transfer_mode_nxt;
         trigger_select_r <= trigger_select_nxt;
         mask_r <= mask_nxt;
         state_r <= state_nxt;
         cur_r <= cur_nxt;
         if (sfr_we && (sfr_addr == `DCAR_ADR_CH0_BASE_HI))
            base0_r[15:8] <= sfr_wdata;
         if (sfr_we && (sfr_addr == `DCAR_ADR_CH0_BASE_LO))
            base0_r[7:0] <= sfr_wdata;
         if (sfr_we && (sfr_addr == `DCAR_ADR_CH14_BASE_HI))
            base1_r[15:8] <= sfr_wdata;
         if (sfr_we && (sfr_addr == `DCAR_ADR_CH14_BASE_LO))
            base1_r[7:0] <= sfr_wdata;
         rvalid_r <= sfr_re;
         if (sfr_re)
         begin
            case (sfr_addr)
               `DCAR_ADR_ARM: rdata_r <= {1'b0, spare_r, arm_r};
               `DCAR_ADR_REQ: rdata_r <= {3'h0, req_r};
               `DCAR_ADR_CH0_BASE_HI: rdata_r <= base0_r[15:8];
               `DCAR_ADR_CH0_BASE_LO: rdata_r <= base0_r[7:0];
               `DCAR_ADR_CH14_BASE_HI: rdata_r <= base1_r[15:8];
               `DCAR_ADR_CH14_BASE_LO: rdata_r <= base1_r[7:0];
               default: rdata_r <= `DCAR_RST_BYTE;
            endcase
         end
         xfer_start_r <= xfer_start_nxt;
         xfer_abort_r <= xfer_abort_nxt;
         xfer_transfer_mode_r <= xfer_transfer_mode_nxt;
         xfer_desc_r <= xfer_desc_nxt;
         done_set_r <= done_set_nxt;
         done_irq_r <= done_irq_nxt;
         mem_req_r <= mem_req_nxt;
         mem_addr_r <= mem_addr_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign sfr_rdata = rdata_r;
   assign sfr_rvalid = rvalid_r;
   assign mem_rd_req = mem_req_r;
   assign mem_rd_addr = mem_addr_r;
   assign xfer_start = xfer_start_r;
   assign xfer_ch = cur_r;
   assign xfer_transfer_mode = xfer_transfer_mode_r;
   assign xfer_desc_addr = xfer_desc_r;
   assign xfer_abort = xfer_abort_r;
   assign done_flag_set = done_set_r;
   assign done_irq = done_irq_r;
   assign channel_arm = arm_r;
   assign busy = (state_r == S_RUN);

endmodule

// File: bench/dcar_top_asserts.sv
// port-level assertions for the dma arm/request control block
`timescale 1ns/1ps
`include "dcar_regs.vh"
module dcar_top_asserts #(
   parameter NCH = 5
) (
   input wire core_clk,
   input wire arst_n,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   input wire sfr_we,
   input wire sfr_re,
   input wire [7:0] sfr_rdata,
   input wire xfer_start,
   input wire [2:0] xfer_ch,
   input wire [1:0] xfer_transfer_mode,
   input wire xfer_abort,
   input wire xfer_done,
   input wire [NCH-1:0] done_flag_set,
   input wire done_irq,
   input wire [NCH-1:0] channel_arm,
   input wire busy
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   reg [NCH-1:0] arm_d_r;
   wire arm_wr = sfr_we && (sfr_addr == `DCAR_ADR_ARM);
   wire run_arm = channel_arm[xfer_ch];
   // grant decision sees the arm bits one cycle before the start pulse
   always @(posedge core_clk or negedge arst_n)
      if (!arst_n)
         arm_d_r <= {NCH{1'b0}};
      else
         arm_d_r <= channel_arm;
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_ARM_RD: assert property (sfr_re && sfr_addr == `DCAR_ADR_ARM |=> !sfr_rdata[7])
      else $error("abort bit read back as one");
   AST_REQ_RD: assert property (sfr_re && sfr_addr == `DCAR_ADR_REQ |=> sfr_rdata[7:5] == 3'h0)
      else $error("request spare bits not zero");
   AST_START_ARMED: assert property (xfer_start |-> arm_d_r[xfer_ch])
      else $error("unarmed channel started");
   AST_ARM_WR: assert property (arm_wr && !sfr_wdata[7] |=> channel_arm == $past(sfr_wdata[4:0]))
      else $error("arm bits differ from written value");
   AST_ABORT: assert property (arm_wr && sfr_wdata[7] |=> (channel_arm & $past(sfr_wdata[4:0])) == 0)
      else $error("aborted channel still armed");
   AST_DISARM: assert property (xfer_done && busy && !xfer_transfer_mode[1] && !arm_wr |=> !run_arm)
      else $error("single or block mode left armed after done");
   AST_KEEP_RPT: assert property (xfer_done && busy && xfer_transfer_mode[1] && run_arm && !arm_wr |=> run_arm)
      else $error("repeated mode lost its arm bit");
   AST_DONE: assert property (xfer_done && busy && run_arm |=> done_flag_set[$past(xfer_ch)] && $onehot(done_flag_set) && !busy)
      else $error("completion flag pulse wrong");
   AST_STOP: assert property (busy && !run_arm && !xfer_done |=> xfer_abort && !busy && done_flag_set == 0)
      else $error("disarmed channel not stopped");
   AST_IRQ: assert property (done_irq |-> $onehot(done_flag_set))
      else $error("interrupt without completion");
   COV_START: cover property (xfer_start);
   COV_ABORT: cover property (xfer_abort);
   COV_IRQ: cover property (done_irq);
endmodule
bind dcar_top dcar_top_asserts #(.NCH(NCH)) u_asserts (.core_clk(core_clk), .arst_n(arst_n),
   .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re),
   .sfr_rdata(sfr_rdata), .xfer_start(xfer_start), .xfer_ch(xfer_ch), .xfer_transfer_mode(xfer_transfer_mode),
   .xfer_abort(xfer_abort), .xfer_done(xfer_done), .done_flag_set(done_flag_set),
   .done_irq(done_irq), .channel_arm(channel_arm), .busy(busy));

// File: bench/dcar_mem_model.sv
// descriptor memory model answering single-byte fetches
`timescale 1ns/1ps
module dcar_mem_model (
   input wire core_clk,
   input wire mem_rd_req,
   input wire [15:0] mem_rd_addr,
   input wire mem_rd_ready,
   output logic mem_rd_valid,
   output logic [7:0] mem_rd_data
);
   logic [7:0] mem [int];
   int delay = 1;
   logic [15:0] a;
   initial
   begin
      mem_rd_valid = 1'b0;
      mem_rd_data = 8'h5a;
      forever
      begin
         @(posedge core_clk);
         if (mem_rd_req === 1'b1)
         begin
            a = mem_rd_addr;
            repeat (delay) @(posedge core_clk);
            @(negedge core_clk);
            mem_rd_valid = 1'b1;
            mem_rd_data = mem.exists(a) ? mem[a] : 8'h00;
            // hold the byte until the buffer takes it
            do @(posedge core_clk); while (mem_rd_ready !== 1'b1);
            @(negedge core_clk);
            mem_rd_valid = 1'b0;
            // released data never keeps the old value
            mem_rd_data = ~mem_rd_data;
         end
      end
   end
endmodule

// File: bench/dcar_top_tb_top.sv
// self-checking bench for the dma arm/request control block
`timescale 1ns/1ps
`include "dcar_regs.vh"
module dcar_top_tb_top;
   logic core_clk, arst_n, sfr_we, sfr_re, xfer_done;
   logic [7:0] sfr_addr, sfr_wdata;
   logic [31:0] trigger_select_in;
   wire [7:0] sfr_rdata, mem_rd_data;
   wire [15:0] mem_rd_addr, xfer_desc_addr;
   wire [2:0] xfer_ch;
   wire [1:0] xfer_transfer_mode;
   wire [4:0] done_flag_set, channel_arm;
   wire sfr_rvalid, mem_rd_req, mem_rd_valid, mem_rd_ready, xfer_start, xfer_abort, done_irq, busy;
   int error_cnt = 0;
   int comparisons = 0;
   logic [15:0] addr_q [$];
   logic [7:0] pv [4] = '{8'h00, 8'h20, 8'h00, 8'h12};
   dcar_top u_dut (.core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata),
      .sfr_rvalid(sfr_rvalid), .trigger_select_in(trigger_select_in), .mem_rd_req(mem_rd_req),
      .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_ready(mem_rd_ready),
      .mem_rd_data(mem_rd_data), .xfer_start(xfer_start), .xfer_ch(xfer_ch),
      .xfer_transfer_mode(xfer_transfer_mode), .xfer_desc_addr(xfer_desc_addr), .xfer_abort(xfer_abort),
      .xfer_done(xfer_done), .done_flag_set(done_flag_set), .done_irq(done_irq),
      .channel_arm(channel_arm), .busy(busy));
   dcar_mem_model u_mem (.core_clk(core_clk), .mem_rd_req(mem_rd_req),
      .mem_rd_addr(mem_rd_addr), .mem_rd_ready(mem_rd_ready), .mem_rd_valid(mem_rd_valid),
      .mem_rd_data(mem_rd_data));
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
      if (mem_rd_req === 1'b1)
         addr_q.push_back(mem_rd_addr);
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      sfr_we = 1'b1;
      sfr_addr = a;
      sfr_wdata = d;
      @(negedge core_clk);
      sfr_we = 1'b0;
   endtask
   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      sfr_re = 1'b1;
      sfr_addr = a;
      @(negedge core_clk);
      sfr_re = 1'b0;
      chk({15'h0, sfr_rvalid}, 16'h1);
      chk({8'h0, sfr_rdata}, {8'h0, exp});
   endtask
   // arm and see the two descriptor byte fetches of the lowest new channel
   task automatic arm_fetch(input logic [7:0] v, input logic [15:0] da);
      int n;
      addr_q.delete();
      sfr_wr(`DCAR_ADR_ARM, v);
      for (n = 0; n < 60 && addr_q.size() < 2; n++)
         @(negedge core_clk);
      chk(16'(addr_q.size() >= 2), 16'h1);
      chk(addr_q[0], da + 16'h6);
      chk(addr_q[1], da + 16'h7);
   endtask
   task automatic wait_start(input logic [2:0] ch, input logic [1:0] tm, input logic [15:0] da);
      int n;
      n = 0;
      while (xfer_start !== 1'b1 && n < 60)
      begin
         @(negedge core_clk);
         n++;
      end
      chk({15'h0, xfer_start}, 16'h1);
      chk({11'h0, xfer_transfer_mode, xfer_ch}, {11'h0, tm, ch});
      chk(xfer_desc_addr, da);
   endtask
   task automatic done_pulse(input logic [4:0] f, input logic irq);
      @(negedge core_clk);
      xfer_done = 1'b1;
      @(negedge core_clk);
      xfer_done = 1'b0;
      chk({11'h0, done_flag_set}, {11'h0, f});
      chk({15'h0, done_irq}, {15'h0, irq});
      chk({15'h0, busy}, 16'h0);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs;
      for (int a = 'hd2; a <= 'hd7; a++)
         sfr_rd(8'(a), 8'h00);
      sfr_rd(8'hd0, 8'h00);
      for (int i = 0; i < 4; i++)
         sfr_wr(8'(8'hd2 + i), pv[i]);
      for (int i = 0; i < 4; i++)
         sfr_rd(8'(8'hd2 + i), pv[i]);
      sfr_wr(`DCAR_ADR_ARM, 8'h60);
      sfr_rd(`DCAR_ADR_ARM, 8'h60);
      sfr_wr(`DCAR_ADR_REQ, 8'he0);
      sfr_rd(`DCAR_ADR_REQ, 8'h00);
      sfr_wr(`DCAR_ADR_ARM, 8'h00);
   endtask
   task automatic t_ch0;
      u_mem.mem[16'h1206] = 8'h00;
      u_mem.mem[16'h1207] = 8'h08;
      arm_fetch(8'h01, 16'h1200);
      sfr_wr(`DCAR_ADR_REQ, 8'h00);
      // trigger lines busy while trigger select is zero: no start may follow
      @(negedge core_clk);
      trigger_select_in = '1;
      repeat (8)
      begin
         @(negedge core_clk);
         chk({15'h0, xfer_start}, 16'h0);
      end
      trigger_select_in = '0;
      sfr_wr(`DCAR_ADR_REQ, 8'h01);
      wait_start(3'h0, 2'h0, 16'h1200);
      sfr_rd(`DCAR_ADR_REQ, 8'h00);
      done_pulse(5'h01, 1'b1);
      sfr_rd(`DCAR_ADR_ARM, 8'h00);
   endtask
   task automatic t_ch2;
      u_mem.delay = 4;
      u_mem.mem[16'h200e] = 8'h60;
      u_mem.mem[16'h200f] = 8'h00;
      arm_fetch(8'h04, 16'h2008);
      sfr_wr(`DCAR_ADR_REQ, 8'h04);
      wait_start(3'h2, 2'h3, 16'h2008);
      done_pulse(5'h04, 1'b0);
      sfr_rd(`DCAR_ADR_ARM, 8'h04);
      sfr_wr(`DCAR_ADR_REQ, 8'h04);
      wait_start(3'h2, 2'h3, 16'h2008);
      sfr_wr(`DCAR_ADR_REQ, 8'h00);
      chk({15'h0, busy}, 16'h1);
      sfr_wr(`DCAR_ADR_ARM, 8'h00);
      @(negedge core_clk);
      chk({14'h0, xfer_abort, busy}, 16'h2);
   endtask
   task automatic t_abort;
      u_mem.delay = 0;
      u_mem.mem[16'h2006] = 8'h20;
      arm_fetch(8'h0a, 16'h2000);
      sfr_wr(`DCAR_ADR_REQ, 8'h02);
      wait_start(3'h1, 2'h1, 16'h2000);
      sfr_wr(`DCAR_ADR_ARM, 8'h82);
      @(negedge core_clk);
      chk({14'h0, xfer_abort, busy}, 16'h2);
      chk({11'h0, channel_arm}, 16'h8);
      sfr_rd(`DCAR_ADR_ARM, 8'h08);
   endtask
   // hardware trigger starts channel 3; its completion chains channel 4
   task automatic t_trigger_select;
      u_mem.mem[16'h2016] = 8'h45;
      u_mem.mem[16'h2017] = 8'h08;
      u_mem.mem[16'h201e] = 8'h01;
      sfr_wr(`DCAR_ADR_ARM, 8'h00);
      arm_fetch(8'h18, 16'h2010);
      // a trigger before the descriptor is loaded would be dropped
      repeat (4) @(negedge core_clk);
      trigger_select_in[5] = 1'b1;
      @(negedge core_clk);
      trigger_select_in[5] = 1'b0;
      wait_start(3'h3, 2'h2, 16'h2010);
      done_pulse(5'h08, 1'b1);
      wait_start(3'h4, 2'h0, 16'h2018);
      done_pulse(5'h10, 1'b0);
      sfr_rd(`DCAR_ADR_ARM, 8'h08);
   endtask
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic conclude;
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      arst_n = 1'b0;
      sfr_we = 1'b0;
      sfr_re = 1'b0;
      xfer_done = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      trigger_select_in = '0;
      repeat (10) @(negedge core_clk);
      arst_n = 1'b1;
      chk({10'h0, mem_rd_ready, channel_arm}, 16'h20);
      t_regs;
      t_ch0;
      t_ch2;
      t_abort;
      t_trigger_select;
      conclude;
   end
   // whole run needs well under a thousand cycles; ten thousand means a hang
   initial
   begin
      #40000;
      error_cnt++;
      conclude;
   end
endmodule
